//--- clk_switch_pkg.sv
package clk_switch_pkg;

    // ************************************************************
    // Select encoding and timing counts
    // ************************************************************
    localparam logic SEL_PRIMARY   = 1'b0;  // Nominal reference input
    localparam logic SEL_ALTERNATE = 1'b1;  // Alternate reference input
    localparam int   NUM_PLLS      = 2;     // Power-down width with switching
    localparam logic [7:0] RECONFIG_CYCLES = 8'h08;  // Reconfiguration time
    localparam logic [3:0] RESET_CYCLES    = 4'h4;   // Reset pulse length
    localparam logic [1:0] PD_RESET_VALUE  = 2'h3;   // Both PLLs powered down

    // Handshake states, Gray coded from ST_IDLE through ST_SETTLE
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_BUSY   = 3'b001,
        ST_DONE   = 3'b011,
        ST_RESET  = 3'b010,
        ST_SETTLE = 3'b110
    } hs_state_t;

endpackage : clk_switch_pkg

//--- clk_switch_if.sv
`timescale 1ns/1ns
`default_nettype none
interface clk_switch_if;
    logic clock_select;      // 0 primary, 1 alternate reference
    logic reconfig_request;  // Held high until done
    logic reconfig_done;     // Completion indication
    logic tx_reset;          // Transmitter reset, active high

    modport device (
        input  clock_select,
        input  reconfig_request,
        input  tx_reset,
        output reconfig_done
    );
    modport host (
        output clock_select,
        output reconfig_request,
        output tx_reset,
        input  reconfig_done
    );
endinterface : clk_switch_if
`default_nettype wire

//--- sync_2ff.sv
`timescale 1ns/1ns
`default_nettype none
module sync_2ff (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Data
    input  wire logic d,
    output var  logic q
);
    logic meta_q;  // First stage, read only by second

    // Two-stage synchroniser
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : sync_2ff
`default_nettype wire

//--- clk_switch_device.sv
`timescale 1ns/1ns
`default_nettype none
module clk_switch_device
#(
    parameter bit PLL_SWITCHING = 1'b1  // Second PLL instead of ref mux
) (
    // Clock and reset
    input  wire logic                                clk,
    input  wire logic                                reset_n,
    // Handshake side
    clk_switch_if.device                             hs,
    // Transceiver side
    input  wire logic                                sd_mode,
    output var  logic                                ref_select,
    output var  logic [clk_switch_pkg::NUM_PLLS-1:0] pll_powerdown,
    output var  logic                                tx_in_reset,
    output var  logic                                switch_failed
);
    import clk_switch_pkg::*;

    // ************************************************************
    // Registers
    // ************************************************************
    logic       sel_pend_q;     // Select captured at request
    logic       req_q;          // Request, previous cycle
    logic       sel_act_q;      // Select that currently drives clock
    // Mode input after the synchroniser
    logic       sd_sync;        // Standard-definition mode, settled
    logic       staged_q;       // Reconfigured, awaiting reset
    logic       rst_seen_q;     // Reset high seen after staging
    logic [7:0] cnt_q;          // Reconfiguration timer
    logic       done_q;         // Done toward host
    hs_state_t  state_q;        // Handshake state

    // ************************************************************
    // Input sampling
    // ************************************************************
    // Handshake inputs share clk with the host logic, so no
    // synchroniser; only the previous request is kept for edges
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // Idle level, so no false edge after reset
            req_q <= 1'b0;
        end else begin
            // Select itself is read directly at the start edge
            req_q <= hs.reconfig_request;
        end
    end

    // ************************************************************
    // Mode input
    // ************************************************************
    // Mode level may come from another domain: two flops first
    // Only a slow level, so the two-cycle lag is harmless
    sync_2ff sync_2ff_i (
        .clk     (clk),
        .reset_n (reset_n),
        .d       (sd_mode),
        .q       (sd_sync)
    );

    // ************************************************************
    // Handshake state machine
    // ************************************************************
    // Request rise starts, done raised after the timer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // Idle, done low, primary captured
            state_q    <= ST_IDLE;
            cnt_q      <= 8'h00;
            done_q     <= 1'b0;
            sel_pend_q <= SEL_PRIMARY;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    // Done stays low while idle
                    done_q <= 1'b0;
                    // Rising request begins reconfiguration; a level
                    // left high from an earlier cycle starts nothing,
                    // and SD mode offers no rate switch
                    if (hs.reconfig_request && !req_q
                        && !sd_sync) begin
                        sel_pend_q <= hs.clock_select;
                        cnt_q      <= RECONFIG_CYCLES;
                        state_q    <= ST_BUSY;
                    end
                end
                ST_BUSY: begin
                    // Count out reconfiguration time
                    if (cnt_q > 8'h01) begin
                        cnt_q <= cnt_q - 8'h01;
                    end else begin
                        // Timer out: raise done
                        done_q  <= 1'b1;
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    // Hold done until request falls
                    if (!hs.reconfig_request) begin
                        // Handshake complete, done falls
                        done_q  <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    // Host-only codes are illegal here; back to idle
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Staging and reset-gated commit
    // ************************************************************
    // New select only drives the clock after a full reset pulse
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // Nothing staged, primary drives the clock
            staged_q      <= 1'b0;
            rst_seen_q    <= 1'b0;
            sel_act_q     <= SEL_PRIMARY;
            switch_failed <= 1'b0;
        end else begin
            if (state_q == ST_DONE && !hs.reconfig_request) begin
                // A select equal to the one already active fails
                if (sel_pend_q == sel_act_q) begin
                    // Clock stays on the old reference
                    switch_failed <= 1'b1;
                    staged_q      <= 1'b0;
                end else begin
                    // Select differs: wait for the reset pulse
                    switch_failed <= 1'b0;
                    staged_q      <= 1'b1;
                end
                rst_seen_q <= 1'b0;
            end else if (staged_q && hs.tx_reset) begin
                // Reset high while staged: first half of the pulse
                rst_seen_q <= 1'b1;
            end else if (staged_q && rst_seen_q && !hs.tx_reset) begin
                // Reset released: the new reference takes over
                sel_act_q  <= sel_pend_q;
                staged_q   <= 1'b0;
                rst_seen_q <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Transceiver controls
    // ************************************************************
    // Active select and reset copy toward the transceiver
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // Primary reference, transmitter held in reset
            ref_select  <= SEL_PRIMARY;
            tx_in_reset <= 1'b1;
        end else begin
            ref_select  <= sel_act_q;
            tx_in_reset <= hs.tx_reset;
        end
    end

    // Power-down per PLL, or a reference mux on one PLL
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // Both PLLs down until reset is released
            pll_powerdown <= PD_RESET_VALUE;
        end else if (PLL_SWITCHING) begin
            // One bit per PLL, idle PLL held down; both down in reset
            pll_powerdown[0] <= hs.tx_reset
                                | (sel_act_q != SEL_PRIMARY);
            pll_powerdown[1] <= hs.tx_reset
                                | (sel_act_q != SEL_ALTERNATE);
        end else begin
            // Single PLL, references muxed, second bit unused
            pll_powerdown <= {1'b0, hs.tx_reset};
        end
    end

    // ************************************************************
    // Done output
    // ************************************************************
    // Done comes straight from its flop
    assign hs.reconfig_done = done_q;

endmodule : clk_switch_device
`default_nettype wire

//--- clk_switch_host.sv
`timescale 1ns/1ns
`default_nettype none
module clk_switch_host (
    // Clock and reset
    input  wire logic     clk,
    input  wire logic     reset_n,
    // User command
    input  wire logic     switch_go,
    input  wire logic     switch_target,
    output var  logic     busy,
    // Handshake side
    clk_switch_if.host    hs
);
    import clk_switch_pkg::*;

    // ************************************************************
    // Registers
    // ************************************************************
    hs_state_t  state_q;   // Host sequence state
    logic       sel_q;     // Select driven to both parties
    logic       req_q;     // Request
    logic       rst_q;     // Transmitter reset
    logic [3:0] rcnt_q;    // Reset pulse counter

    // Host sequence: select and request together, wait done, reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            sel_q   <= SEL_PRIMARY;
            req_q   <= 1'b0;
            rst_q   <= 1'b0;
            rcnt_q  <= 4'h0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (switch_go) begin
                        sel_q   <= switch_target;
                        req_q   <= 1'b1;
                        state_q <= ST_BUSY;
                    end
                end
                ST_BUSY: begin
                    // Request and select held until done
                    if (hs.reconfig_done) begin
                        req_q   <= 1'b0;
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    rst_q   <= 1'b1;
                    rcnt_q  <= RESET_CYCLES;
                    state_q <= ST_RESET;
                end
                ST_RESET: begin
                    // Reset high then low commits the clock
                    if (rcnt_q > 4'h1) begin
                        rcnt_q <= rcnt_q - 4'h1;
                    end else begin
                        rst_q   <= 1'b0;
                        state_q <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Busy straight from a flop
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy <= 1'b0;
        end else begin
            busy <= (state_q != ST_IDLE) || switch_go;
        end
    end

    assign hs.clock_select     = sel_q;
    assign hs.reconfig_request = req_q;
    assign hs.tx_reset         = rst_q;

endmodule : clk_switch_host
`default_nettype wire

//--- clk_switch_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module clk_switch_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Handshake signals
    input wire logic clock_select,
    input wire logic reconfig_request,
    input wire logic reconfig_done,
    input wire logic tx_reset,
    // Mode input of the device
    input wire logic sd_mode
);
    // ************************************************************
    // Handshake checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Reset pulse of four cycles, then low
    sequence tx_reset_pulse;
        tx_reset [*4] ##1 !tx_reset;
    endsequence

    // Request rises while the mode input is not SD
    sequence request_start;
        $rose(reconfig_request) && !sd_mode;
    endsequence

    chk_done_after_start: assert property (
        request_start |-> ##[8:10] $rose(reconfig_done))
        else $error("done did not follow request");
    chk_request_held: assert property (
        reconfig_request && !reconfig_done |=> reconfig_request)
        else $error("request dropped before done");
    chk_done_needs_req: assert property (
        $rose(reconfig_done) |-> reconfig_request)
        else $error("done without request");
    chk_select_stable: assert property (
        reconfig_request && !reconfig_done |=> $stable(clock_select))
        else $error("select moved during reconfiguration");
    chk_request_drop: assert property (
        $rose(reconfig_done) |-> ##[1:2] !reconfig_request)
        else $error("request not dropped after done");
    chk_select_with_req: assert property (
        $changed(clock_select) |-> $rose(reconfig_request))
        else $error("select changed without request");
    chk_reset_follows: assert property (
        $fell(reconfig_request) |=> $rose(tx_reset))
        else $error("reset not raised after request drop");
    chk_reset_pulse_len: assert property (
        $rose(tx_reset) |-> tx_reset_pulse)
        else $error("reset pulse length wrong");
    chk_done_release: assert property (
        reconfig_done && !reconfig_request |=> !reconfig_done)
        else $error("done held after request dropped");
    chk_sd_no_done: assert property (
        sd_mode && !reconfig_done |=> !reconfig_done)
        else $error("done raised in sd mode");
endmodule : clk_switch_asserts
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
    import clk_switch_pkg::*;
    // ************************************************************
    // Clock, reset and design ends
    // ************************************************************
    logic                clk = 1'b0;       // 10 MHz clock
    logic                reset_n = 1'b0;   // Async reset, active low
    logic                switch_go = 1'b0; // Start pulse
    logic                switch_target = 1'b0;  // Wanted reference
    logic                sd_mode = 1'b0;   // Blocks switching
    logic                busy;             // Host busy
    logic                ref_select;       // Active reference
    logic [NUM_PLLS-1:0] pll_powerdown;    // PLL power-down
    logic                tx_in_reset;      // Transmitter reset copy
    logic                switch_failed;    // Failed switch flag
    logic                mux_ref_select;   // Active reference, one PLL
    logic [NUM_PLLS-1:0] mux_powerdown;    // Power-down, one PLL
    int                  fails = 0;        // Mismatch count
    int                  num_checks = 0;   // Comparison count

    // One clock stands in for both references; rate not modelled
    always #50 clk = ~clk;

    // Same select reaches both ends through one interface
    clk_switch_if hs_if ();
    clk_switch_device #(.PLL_SWITCHING(1'b1)) clk_switch_device_i (
        .clk(clk), .reset_n(reset_n), .hs(hs_if), .sd_mode(sd_mode),
        .ref_select(ref_select), .pll_powerdown(pll_powerdown),
        .tx_in_reset(tx_in_reset), .switch_failed(switch_failed));
    clk_switch_host clk_switch_host_i (
        .clk(clk), .reset_n(reset_n), .switch_go(switch_go),
        .switch_target(switch_target), .busy(busy), .hs(hs_if));
    clk_switch_asserts clk_switch_asserts_i (
        .clk(clk), .reset_n(reset_n),
        .clock_select(hs_if.clock_select),
        .reconfig_request(hs_if.reconfig_request),
        .reconfig_done(hs_if.reconfig_done),
        .tx_reset(hs_if.tx_reset), .sd_mode(sd_mode));
    // Lockstep pair with one PLL and a reference mux
    clk_switch_if mux_if ();
    clk_switch_device #(.PLL_SWITCHING(1'b0)) clk_switch_device_mux_i (
        .clk(clk), .reset_n(reset_n), .hs(mux_if), .sd_mode(sd_mode),
        .ref_select(mux_ref_select), .pll_powerdown(mux_powerdown),
        .tx_in_reset(), .switch_failed());
    clk_switch_host clk_switch_host_mux_i (
        .clk(clk), .reset_n(reset_n), .switch_go(switch_go),
        .switch_target(switch_target), .busy(), .hs(mux_if));

    // Verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    // Reset for 20 cycles, then check reset values
    task automatic do_reset();
        reset_n = 1'b0;
        repeat (20) @(posedge clk);
        #1 reset_n = 1'b1;
        `CHK(ref_select, SEL_PRIMARY)
        `CHK(pll_powerdown, PD_RESET_VALUE)
        `CHK(hs_if.reconfig_done, 1'b0)
        `CHK(busy, 1'b0)
        `CHK(tx_in_reset, 1'b1)
        `CHK(switch_failed, 1'b0)
        `CHK(mux_powerdown, PD_RESET_VALUE)
    endtask : do_reset

    // One switch request; old select must still hold when the reset pulse starts
    task automatic switch_to(input logic tgt, input logic exp_sel,
                             input logic exp_fail);
        logic old_sel;
        int   n;
        logic [NUM_PLLS-1:0] exp_pd;
        old_sel = ref_select;
        @(posedge clk) #1 switch_go = 1'b1;
        switch_target = tgt;
        @(posedge clk) #1 switch_go = 1'b0;
        n = 0;
        while (hs_if.tx_reset !== 1'b1 && n < 100) begin
            @(posedge clk) #1 n++;
        end
        `CHK(ref_select, old_sel)
        while (hs_if.tx_reset === 1'b1 && n < 200) begin
            @(posedge clk) #1 n++;
        end
        // Last reset cycle: both PLLs down, reset copy high
        `CHK(tx_in_reset, 1'b1)
        `CHK(pll_powerdown, 2'h3)
        `CHK(mux_powerdown, 2'h1)
        repeat (4) @(posedge clk);
        // Idle PLL stays powered down after the switch
        exp_pd = {exp_sel == SEL_PRIMARY, exp_sel == SEL_ALTERNATE};
        #1 `CHK(ref_select, exp_sel)
        `CHK(switch_failed, exp_fail)
        `CHK(busy, 1'b0)
        `CHK(tx_in_reset, 1'b0)
        `CHK(pll_powerdown, exp_pd)
        `CHK(mux_ref_select, exp_sel)
        `CHK(mux_powerdown, 2'h0)
    endtask : switch_to

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        do_reset();
        `CHK($bits(pll_powerdown), 2)
        switch_to(SEL_ALTERNATE, SEL_ALTERNATE, 1'b0);
        switch_to(SEL_PRIMARY, SEL_PRIMARY, 1'b0);
        switch_to(SEL_PRIMARY, SEL_PRIMARY, 1'b1);
        switch_to(SEL_ALTERNATE, SEL_ALTERNATE, 1'b0);
        // Standard definition blocks the switch; recover by reset
        sd_mode = 1'b1;
        @(posedge clk) #1 switch_go = 1'b1;
        switch_target = SEL_PRIMARY;
        @(posedge clk) #1 switch_go = 1'b0;
        repeat (20) @(posedge clk);
        #1 `CHK(hs_if.reconfig_done, 1'b0)
        `CHK(ref_select, SEL_ALTERNATE)
        sd_mode = 1'b0;
        do_reset();
        switch_to(SEL_ALTERNATE, SEL_ALTERNATE, 1'b0);
        tally_and_finish();
    end

    // Watchdog against a hung handshake
    initial begin
        #(2000 * 100);
        fails++;
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
